// ---- dv/tbg_gateway_checker.sv ----
`timescale 1ns/10ps
// port-level watcher for the barrier gateway
module tbg_gateway_checker (
    input wire logic        i_clock,
    input wire logic        i_nrst,
    input wire logic        i_msg_valid,
    input wire logic        i_msg_pred,
    input wire logic [31:0] i_msg_dw2,
    input wire logic [31:0] i_msg_dw3,
    input wire logic [2:0]  i_msg_subslice,
    input wire logic        i_ctx_restore,
    input wire logic [31:0] i_ctx_pool,
    input wire logic        o_msg_ready,
    input wire logic        o_release,
    input wire logic [4:0]  o_release_id,
    input wire logic [31:0] o_release_mask,
    input wire logic [2:0]  o_release_subslice,
    input wire logic        o_pooled_dispatch,
    input wire logic        o_single_subslice_dispatch,
    input wire logic [31:0] o_ctx_pool
);
    // a message is taken on valid with ready
    wire logic       take = i_msg_valid & o_msg_ready;
    wire logic [4:0] msg_id = {i_msg_dw2[31], i_msg_dw2[27:24]};
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    a_ready_gap: assert property (
        take |=> !o_msg_ready) else $error("ready held after take");
    a_rel_pulse: assert property (
        o_release |=> !o_release) else $error("release longer than 1");
    a_rel_cause: assert property (
        o_release |-> $past(take, 3)) else $error("release without msg");
    a_rel_id: assert property (
        take |-> ##3 (!o_release || o_release_id == $past(msg_id, 3)))
        else $error("release id wrong");
    a_mask_pred: assert property (
        take && i_msg_pred |-> ##3
        (!o_release || o_release_mask == $past(i_msg_dw3, 3)))
        else $error("predicate mask wrong");
    a_mask_ignored: assert property (
        take && !i_msg_pred |-> ##3
        (!o_release || o_release_mask == 32'hffff_ffff))
        else $error("mask not ignored");
    a_count_zero: assert property (
        take && i_msg_dw2[15] && i_msg_dw2[14:9] == 6'h00 |-> ##3 o_release)
        else $error("zero count did not release");
    a_mode_excl: assert property (
        o_pooled_dispatch != o_single_subslice_dispatch)
        else $error("dispatch modes overlap");
    a_mode_reset: assert property (
        disable iff (1'b0) !i_nrst |=> o_single_subslice_dispatch)
        else $error("reset mode not single");
    a_pool_ss: assert property (
        take && o_pooled_dispatch |-> ##3
        (!o_release || o_release_subslice == 3'h7))
        else $error("pooled release not pool wide");
    a_local_ss: assert property (
        take && o_single_subslice_dispatch |-> ##3
        (!o_release || o_release_subslice == $past(i_msg_subslice, 3)))
        else $error("local release subslice wrong");
    // image flop sits one edge behind the pool register
    a_ctx_keep: assert property (
        i_ctx_restore |-> ##2 o_ctx_pool == $past(i_ctx_pool, 2))
        else $error("pool state not restored");
endmodule // tbg_gateway_checker

bind tbg_gateway tbg_gateway_checker u_chk (.i_clock, .i_nrst, .i_msg_valid,
    .i_msg_pred, .i_msg_dw2, .i_msg_dw3, .i_msg_subslice, .i_ctx_restore,
    .i_ctx_pool, .o_msg_ready, .o_release, .o_release_id, .o_release_mask,
    .o_release_subslice, .o_pooled_dispatch, .o_single_subslice_dispatch,
    .o_ctx_pool);

// ---- dv/tbg_thread_model.sv ----
`timescale 1ns/10ps
// shader thread sending one barrier message at a time
module tbg_thread_model (
    input  wire logic        i_clock,
    input  wire logic        i_ready,
    output logic             o_valid = 1'b0,
    output logic             o_pred  = 1'b0,
    output logic [31:0]      o_dw2   = 32'h0,
    output logic [31:0]      o_dw3   = 32'h0,
    output logic [2:0]       o_ss    = 3'h0
);
    // set when a message is never taken
    bit stuck = 1'b0;

    task automatic send(input logic [31:0] dw2, input logic [31:0] dw3,
                        input logic pred, input logic [2:0] ss);
        int n;
        n = 0;
        @(posedge i_clock);
        o_valid <= 1'b1;
        o_dw2   <= dw2;
        o_dw3   <= dw3;
        o_pred  <= pred;
        o_ss    <= ss;
        do begin
            @(posedge i_clock);
            n++;
        end while (i_ready !== 1'b1 && n < 50);
        if (i_ready !== 1'b1)
            stuck = 1'b1;
        // dword lines turn over once idle so stale values cannot pass
        o_valid <= 1'b0;
        o_dw2   <= ~dw2;
        o_dw3   <= ~dw3;
    endtask
endmodule // tbg_thread_model

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
`include "tbg_regs.vh"
// self-checking bench for the barrier gateway
module testbench;
    typedef struct packed {
        logic [31:0] dw2;
        logic [31:0] dw3;
        logic        pred;
        logic [2:0]  ss;
        logic        rel;
        logic [31:0] mask;
    } tbg_row_t;
    logic        clk = 1'b0, nrst = 1'b0, ctx_rst = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, ctx_pool = 32'h0, rd;
    logic        er;
    wire  [31:0] prdata, rel_mask, o_pool, dw2, dw3;
    wire  [4:0]  rel_id;
    wire  [2:0]  rel_ss, ss;
    wire         pready, pslverr, ready, rel, pooled, single, valid, pred;
    int          num_errors = 0, n_checks = 0;
    tbg_row_t    rows [8];

    always #5 clk = ~clk;

    tbg_thread_model u_thr (.i_clock(clk), .i_ready(ready), .o_valid(valid),
        .o_pred(pred), .o_dw2(dw2), .o_dw3(dw3), .o_ss(ss));
    tbg_gateway DUT (.i_clock(clk), .i_nrst(nrst), .i_msg_valid(valid),
        .i_msg_pred(pred), .i_msg_dw2(dw2), .i_msg_dw3(dw3),
        .i_msg_subslice(ss), .i_ctx_restore(ctx_rst), .i_ctx_pool(ctx_pool),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_msg_ready(ready),
        .o_release(rel), .o_release_id(rel_id), .o_release_mask(rel_mask),
        .o_release_subslice(rel_ss), .o_pooled_dispatch(pooled),
        .o_single_subslice_dispatch(single), .o_ctx_pool(o_pool));

    // header dword 2 built from id msb, id, count enable and count
    function automatic logic [31:0] mk(input logic b4, input logic [3:0] id,
                                       input logic en, input logic [5:0] c);
        mk = {b4, 3'h0, id, 8'h00, en, c, 9'h000};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; waits on pready, no fixed latency assumed
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (pready !== 1'b1)
            num_errors++;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        report_and_stop;
    end

    initial begin
        rows[0] = '{mk(0, 4'h3, 1, 6'h02), 32'h0, 0, 3'h1, 0, 32'h0};
        rows[1] = '{mk(0, 4'h5, 1, 6'h01), 32'hff, 1, 3'h2, 1, 32'hff};
        rows[2] = '{mk(0, 4'h3, 0, 6'h02), 32'h5, 0, 3'h1, 1, 32'hffffffff};
        rows[3] = '{mk(0, 4'h3, 0, 6'h00), 32'h0, 0, 3'h3, 0, 32'h0};
        rows[4] = '{mk(0, 4'h3, 0, 6'h00), 32'h0, 0, 3'h3, 1, 32'hffffffff};
        rows[5] = '{mk(1, 4'h2, 0, 6'h05), 32'hffff, 1, 3'h4, 1, 32'hffff};
        rows[6] = '{mk(1, 4'h2, 0, 6'h09), 32'h1234, 0, 3'h6, 1, 32'hffffffff};
        rows[7] = '{mk(0, 4'h7, 1, 6'h00), 32'h0, 0, 3'h0, 1, 32'hffffffff};
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        chk(single, 1'b1);
        chk(pooled, 1'b0);
        $display("reset test done");
        // send returns at the take edge; release stands after two more
        foreach (rows[i]) begin
            u_thr.send(rows[i].dw2, rows[i].dw3, rows[i].pred, rows[i].ss);
            repeat (2) @(posedge clk);
            #1;
            chk(rel, rows[i].rel);
            if (rows[i].rel) begin
                chk(rel_id, {rows[i].dw2[31], rows[i].dw2[27:24]});
                chk(rel_mask, rows[i].mask);
                chk(rel_ss, rows[i].ss);
            end
        end
        $display("message table done");
        apb(1, `TBG_OFF_COUNT_RD, 32'h3);
        repeat (2) @(posedge clk);
        apb(0, `TBG_OFF_COUNT_RD, 32'h0);
        chk(rd, 32'h2);
        apb(0, 12'h010, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        apb(1, `TBG_OFF_CTRL, 32'h1);
        // mode flops follow the control register one edge later
        @(posedge clk);
        #1;
        chk({pooled, single}, 2'b10);
        u_thr.send(mk(0, 4'h5, 0, 6'h00), 32'h0, 0, 3'h2);
        repeat (2) @(posedge clk);
        #1;
        chk({rel, rel_ss}, {1'b1, 3'h7});
        // seven releases so far, no update pending
        apb(0, `TBG_OFF_STATUS, 32'h0);
        chk(rd, 32'h0000_0700);
        $display("register test done");
        @(posedge clk);
        ctx_rst  <= 1'b1;
        ctx_pool <= 32'h0000_a5a4;
        @(posedge clk);
        ctx_rst  <= 1'b0;
        // image and mode flops sit one edge behind the pool register
        @(posedge clk);
        #1;
        chk(o_pool, 32'h0000_a5a4);
        chk({pooled, single}, 2'b01);
        apb(0, `TBG_OFF_POOL, 32'h0);
        chk(rd, 32'h0000_a5a4);
        apb(1, `TBG_OFF_CTRL, 32'h1);
        // second reset in mid-run must bring back single mode
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        apb(0, `TBG_OFF_CTRL, 32'h0);
        chk({pooled, single}, 2'b01);
        chk(rd, 32'h0);
        chk(u_thr.stuck, 1'b0);
        $display("context and reset test done");
        report_and_stop;
    end
endmodule // testbench

// ---- verilog/tbg_apb_slave.v ----
`timescale 1ns/10ps
`include "tbg_regs.vh"
// zero-wait-state apb slave; decoding only, storage lives in the top
module tbg_apb_slave (
    input  wire        i_clock,
    input  wire        i_nrst,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_rd_ctrl,
    input  wire [31:0] i_rd_status,
    input  wire [31:0] i_rd_pool,
    input  wire [31:0] i_rd_count,
    output wire        o_wr_ctrl,
    output wire        o_wr_pool,
    output wire        o_wr_count,
    output reg  [31:0] o_prdata,
    output reg         o_pslverr
);
    wire acc;
    reg  [31:0] rd_d;
    reg         hit_d;

    // write strobes only at the access edge
    assign acc        = i_psel & i_penable;
    assign o_wr_ctrl  = acc & i_pwrite & (i_paddr == `TBG_OFF_CTRL);
    assign o_wr_pool  = acc & i_pwrite & (i_paddr == `TBG_OFF_POOL);
    assign o_wr_count = acc & i_pwrite & (i_paddr == `TBG_OFF_COUNT_RD);

    // read mux; unmapped reads return zero with an error
    always @* begin
        rd_d  = 32'h0000_0000;
        hit_d = 1'b1;
        case (i_paddr)
            `TBG_OFF_CTRL:     rd_d = i_rd_ctrl;
            `TBG_OFF_STATUS:   rd_d = i_rd_status;
            `TBG_OFF_POOL:     rd_d = i_rd_pool;
            `TBG_OFF_COUNT_RD: rd_d = i_rd_count;
            default:           hit_d = 1'b0;
        endcase
    end

    // data registered in the setup cycle so pready may stay high
    always @(posedge i_clock) begin
        if (!i_nrst) begin
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (i_psel & ~i_penable) begin
            o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_d;
            o_pslverr <= ~hit_d;
        end
    end
endmodule // tbg_apb_slave

// ---- verilog/tbg_gateway.v ----
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "tbg_regs.vh"
// Overview of operation
// - senders give a 32-bit per-channel predicate mask, upper bits zero for narrow threads.
// - the predicate mask is ignored unless the barrier is predicated.
// - the five-bit barrier id is header bit 31 above the four-bit id field.
// - bits 27 to 24 pick one of sixteen barrier states to update.
// - with bit 15 set the count field replaces the stored count and is used now.
// - with bit 15 clear the stored count is kept and used.
// - the count field at bits 14 to 9 is read only when reprogramming is on.
// - pooled mode lets a workgroup spread over exec units of several subslices.
// - single-subslice mode keeps a workgroup, its memory bank and barriers in one subslice.
// - single-subslice mode is the reset state, one global bit picks the mode.
// - pool configuration is context state, saved and restored; the saved image carries the mode bit in place of pool bit 0.
module tbg_gateway (
    input  wire        i_clock,
    input  wire        i_nrst,
    // barrier message, one beat per valid
    input  wire        i_msg_valid,
    input  wire        i_msg_pred,
    input  wire [31:0] i_msg_dw2,
    input  wire [31:0] i_msg_dw3,
    input  wire [2:0]  i_msg_subslice,
    // context save and restore of pool state
    input  wire        i_ctx_restore,
    input  wire [31:0] i_ctx_pool,
    // apb
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output wire [31:0] o_prdata,
    output wire        o_pready,
    output wire        o_pslverr,
    // outputs
    output reg         o_msg_ready,
    output reg         o_release,
    output reg  [4:0]  o_release_id,
    output reg  [31:0] o_release_mask,
    output reg  [2:0]  o_release_subslice,
    output reg         o_pooled_dispatch,
    output reg         o_single_subslice_dispatch,
    output reg  [31:0] o_ctx_pool
);
    localparam ST_IDLE = 2'b01;
    localparam ST_UPD  = 2'b10;

    reg  [1:0]  state_q;
    reg  [31:0] ctrl_q;
    reg  [31:0] pool_q;
    reg  [3:0]  rd_slot_q;
    reg  [4:0]  id_q;
    reg  [31:0] mask_q;
    reg  [2:0]  sub_q;
    reg         cnt_en_q;
    reg  [5:0]  cnt_val_q;
    reg  [7:0]  rel_cnt_q;
    wire        upd;
    wire        rel;
    wire [5:0]  rd_term;
    wire        wr_ctrl;
    wire        wr_pool;
    wire        wr_count;
    wire [31:0] status;

    // two-state accept machine; one message per two cycles
    always @(posedge i_clock) begin
        if (!i_nrst) begin
            state_q     <= ST_IDLE;
            o_msg_ready <= 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: if (i_msg_valid) begin
                    state_q     <= ST_UPD;
                    o_msg_ready <= 1'b0;
                end
                ST_UPD: begin
                    state_q     <= ST_IDLE;
                    o_msg_ready <= 1'b1;
                end
                default: begin
                    state_q     <= ST_IDLE;
                    o_msg_ready <= 1'b1;
                end
            endcase
        end
    end

    // capture the message fields
    always @(posedge i_clock) begin
        if (!i_nrst) begin
            id_q      <= 5'h00;
            mask_q    <= 32'h0000_0000;
            sub_q     <= 3'h0;
            cnt_en_q  <= 1'b0;
            cnt_val_q <= 6'h00;
        end else if (state_q == ST_IDLE && i_msg_valid) begin
            id_q <= {i_msg_dw2[`TBG_M2_ID_MSB],
                     i_msg_dw2[`TBG_M2_ID_HI:`TBG_M2_ID_LO]};
            mask_q <= i_msg_pred ? i_msg_dw3 : 32'hffff_ffff;
            sub_q  <= i_msg_subslice;
            cnt_en_q <= i_msg_dw2[`TBG_M2_CNT_EN];
            cnt_val_q <= i_msg_dw2[`TBG_M2_CNT_EN] ?
                i_msg_dw2[`TBG_M2_CNT_HI:`TBG_M2_CNT_LO] : 6'h00;
        end
    end

    assign upd = (state_q == ST_UPD);

    // sixteen barrier states; id bit 4 is reported, not stored
    tbg_slot_mem u_slots (
        .i_clock   (i_clock),
        .i_nrst    (i_nrst),
        .i_upd     (upd),
        .i_slot    (id_q[3:0]),
        .i_cnt_en  (cnt_en_q),
        .i_cnt_val (cnt_val_q),
        .i_rd_slot (rd_slot_q),
        .o_rd_term (rd_term),
        .o_release (rel)
    );

    // latch details of the updated barrier for the release
    reg [4:0]  upd_id_q;
    reg [31:0] upd_mask_q;
    reg [2:0]  upd_sub_q;
    always @(posedge i_clock) begin
        if (!i_nrst) begin
            upd_id_q   <= 5'h00;
            upd_mask_q <= 32'h0000_0000;
            upd_sub_q  <= 3'h0;
        end else if (upd) begin
            upd_id_q   <= id_q;
            upd_mask_q <= mask_q;
            upd_sub_q  <= sub_q;
        end
    end

    always @(posedge i_clock) begin
        if (!i_nrst) begin
            o_release          <= 1'b0;
            o_release_id       <= 5'h00;
            o_release_mask     <= 32'h0000_0000;
            o_release_subslice <= 3'h0;
            rel_cnt_q          <= 8'h00;
        end else begin
            o_release <= rel;
            if (rel) begin
                o_release_id   <= upd_id_q;
                o_release_mask <= upd_mask_q;
                o_release_subslice <= o_pooled_dispatch ?
                    3'h7 : upd_sub_q;
                rel_cnt_q <= rel_cnt_q + 8'h01;
            end
        end
    end

    tbg_apb_slave u_apb (
        .i_clock     (i_clock),
        .i_nrst      (i_nrst),
        .i_psel      (i_psel),
        .i_penable   (i_penable),
        .i_pwrite    (i_pwrite),
        .i_paddr     (i_paddr),
        .i_rd_ctrl   (ctrl_q),
        .i_rd_status (status),
        .i_rd_pool   (pool_q),
        .i_rd_count  ({26'h0000000, rd_term}),
        .o_wr_ctrl   (wr_ctrl),
        .o_wr_pool   (wr_pool),
        .o_wr_count  (wr_count),
        .o_prdata    (o_prdata),
        .o_pslverr   (o_pslverr)
    );
    assign o_pready = 1'b1;
    assign status   = {16'h0000, rel_cnt_q, 7'h00, upd};

    // control, pool and slot-select registers
    always @(posedge i_clock) begin
        if (!i_nrst) begin
            ctrl_q    <= `TBG_CTRL_RST_VAL;
            pool_q    <= `TBG_POOL_RST;
            rd_slot_q <= 4'h0;
        end else begin
            if (wr_ctrl)
                ctrl_q <= {31'h00000000, i_pwdata[`TBG_CTRL_POOLED]};
            if (i_ctx_restore) begin
                pool_q <= i_ctx_pool;
                ctrl_q <= {31'h00000000, i_ctx_pool[`TBG_CTRL_POOLED]};
            end else if (wr_pool)
                pool_q <= i_pwdata;
            if (wr_count)
                rd_slot_q <= i_pwdata[3:0];
        end
    end

    always @(posedge i_clock) begin
        if (!i_nrst) begin
            o_pooled_dispatch          <= 1'b0;
            o_single_subslice_dispatch <= 1'b1;
            o_ctx_pool                 <= `TBG_POOL_RST;
        end else begin
            o_pooled_dispatch          <= ctrl_q[`TBG_CTRL_POOLED];
            o_single_subslice_dispatch <= ~ctrl_q[`TBG_CTRL_POOLED];
            o_ctx_pool <= {pool_q[31:1], ctrl_q[`TBG_CTRL_POOLED]};
        end
    end
endmodule // tbg_gateway

// ---- verilog/tbg_regs.vh ----
`ifndef TBG_REGS_VH
`define TBG_REGS_VH
// apb register byte offsets
`define TBG_OFF_CTRL       12'h000
`define TBG_OFF_STATUS     12'h004
`define TBG_OFF_POOL       12'h008
`define TBG_OFF_COUNT_RD   12'h00c
// control register fields
`define TBG_CTRL_POOLED    0
`define TBG_CTRL_RST_VAL   32'h0000_0000
// status register fields
`define TBG_STAT_BUSY      0
`define TBG_STAT_REL_LO    8
// message header dword 2 fields
`define TBG_M2_ID_MSB      31
`define TBG_M2_ID_HI       27
`define TBG_M2_ID_LO       24
`define TBG_M2_CNT_EN      15
`define TBG_M2_CNT_HI      14
`define TBG_M2_CNT_LO      9
// barrier state counts and widths
`define TBG_NUM_SLOTS      16
`define TBG_CNT_W          6
`define TBG_CNT_RST        6'h00
`define TBG_POOL_RST       32'h0000_0000
`endif

// ---- verilog/tbg_slot_mem.v ----
`timescale 1ns/10ps
`include "tbg_regs.vh"
// per-slot barrier state: terminating count and arrivals
module tbg_slot_mem (
    input  wire       i_clock,
    input  wire       i_nrst,
    input  wire       i_upd,
    input  wire [3:0] i_slot,
    input  wire       i_cnt_en,
    input  wire [5:0] i_cnt_val,
    input  wire [3:0] i_rd_slot,
    output reg  [5:0] o_rd_term,
    output reg        o_release
);
    reg  [5:0] term_q [0:`TBG_NUM_SLOTS-1];
    reg  [5:0] arr_q  [0:`TBG_NUM_SLOTS-1];
    wire [5:0] eff_term;
    wire [5:0] arr_inc;
    wire       hit;

    assign eff_term = i_cnt_en ? i_cnt_val : term_q[i_slot];
    assign arr_inc  = arr_q[i_slot] + 6'h01;
    assign hit      = (arr_inc == eff_term) | (eff_term == 6'h00);

    genvar g;
    generate
        for (g = 0; g < `TBG_NUM_SLOTS; g = g + 1) begin : g_slot
            // one state per slot, only the selected one moves
            always @(posedge i_clock) begin
                if (!i_nrst) begin
                    term_q[g] <= `TBG_CNT_RST;
                    arr_q[g]  <= `TBG_CNT_RST;
                end else if (i_upd && i_slot == g) begin
                    if (i_cnt_en)
                        term_q[g] <= i_cnt_val;
                    arr_q[g] <= hit ? 6'h00 : arr_inc;
                end
            end
        end
    endgenerate

    // registered read port and release pulse
    always @(posedge i_clock) begin
        if (!i_nrst) begin
            o_rd_term <= `TBG_CNT_RST;
            o_release <= 1'b0;
        end else begin
            o_rd_term <= term_q[i_rd_slot];
            o_release <= i_upd & hit;
        end
    end
endmodule // tbg_slot_mem
